// >>> core/trt_test_port.sv
// Contract
// - ID word bit 0 is always one
// - ID bits 27:23 hold depth code 00111
// - ID bits 22:18 hold width code 00011
// - ID bits 31:28 hold a revision number
// - ID bits 17:12 are a reserved field
// - ID bits 11:1 hold the maker code
// - Codes 000/010 capture ring, chain, outputs high-Z
// - Code 000 captures only, never drives pins
// - Code 001 loads ID word into path
// - Code 100 samples ring, no preload, no effect
// - Code 111 selects one-bit bypass path
// - Test data out changes after clock fall
// - Data in and mode sampled on rise
// - ID path is 32 bits, LSB first
// - Instruction capture loads 01 into low bits
// - Reset and test-logic-reset select ID read
// - New instruction acts only at update
module trt_test_port (
   input  wire logic                           clk,
   input  wire logic                           rst,
   input  wire logic                           tck,
   input  wire logic                           tms,
   input  wire logic                           tdi,
   input  wire logic [trt_pkg::BSR_W-1:0]      ring,
   output logic                                tdo,
   output logic                                tdo_oe,
   output logic                                hiz,
   input  wire logic                           psel,
   input  wire logic                           penable,
   input  wire logic                           pwrite,
   input  wire logic [trt_pkg::APB_AW-1:0]     paddr,
   input  wire logic [31:0]                    pwdata,
   output logic [31:0]                         prdata,
   output logic                                pready,
   output logic                                pslverr
);

   localparam logic [1:0] PATH_BYP = 2'h0;
   localparam logic [1:0] PATH_ID  = 2'h1;
   localparam logic [1:0] PATH_BSR = 2'h2;

   trt_pkg::trt_jtag_t              pin_s;
   logic [2:0]                      pin_v;
   logic [trt_pkg::BSR_W-1:0]       ring_s;
   trt_pkg::trt_tap_t               state;
   trt_pkg::trt_core_t              st_q;
   trt_pkg::trt_core_t              st_d;
   logic                            rise;
   logic                            fall;
   logic [trt_pkg::ID_W-1:0]        id_word;
   logic [1:0]                      path;
   logic                            access;
   logic [31:0]                     stat_word;

   // Test clock is only a sampled level here; edges come from the sampler
   trt_sync #(
      .W (3)
   ) u_pin_sync (
      .clk (clk),
      .rst (rst),
      .d   ({tck, tms, tdi}),
      .q   (pin_v)
   );
   assign pin_s = trt_pkg::trt_jtag_t'(pin_v);

   // Ring pins are asynchronous to us; a moving pin just settles late
   trt_sync #(
      .W (trt_pkg::BSR_W)
   ) u_ring_sync (
      .clk (clk),
      .rst (rst),
      .d   (ring),
      .q   (ring_s)
   );

   trt_tap_fsm u_fsm (
      .clk   (clk),
      .rst   (rst),
      .step  (rise),
      .tms   (pin_s.tms),
      .state (state)
   );

   // Mode and data share sampler latency, so rise sees them aligned
   assign rise = pin_s.tck & ~st_q.tck_prev;
   assign fall = ~pin_s.tck & st_q.tck_prev;

   // Identification word, LSB is the presence marker
   assign id_word = {st_q.rev,
                     trt_pkg::ID_DEPTH,
                     trt_pkg::ID_WIDTH,
                     st_q.rsvd,
                     trt_pkg::ID_MFR,
                     1'b1};

   // Path select; unnamed codes fall back to bypass as the safe choice
   always_comb begin
      case (st_q.ir_act)
         trt_pkg::INS_EXT:  path = PATH_BSR;
         trt_pkg::INS_SMPZ: path = PATH_BSR;
         trt_pkg::INS_SMP:  path = PATH_BSR;
         trt_pkg::INS_IDC:  path = PATH_ID;
         trt_pkg::INS_BYP:  path = PATH_BYP;
         default:           path = PATH_BYP;
      endcase
   end

   assign access = psel & penable & ~st_q.pready;

   // Status view of the port
   always_comb begin
      stat_word = 32'h0;
      stat_word[trt_pkg::STAT_TAP_LSB +: 4] = state;
      stat_word[trt_pkg::STAT_IR_LSB +: 3]  = st_q.ir_act;
      stat_word[trt_pkg::STAT_HIZ_BIT]      = st_q.hiz;
      stat_word[trt_pkg::STAT_OE_BIT]       = st_q.tdo_oe;
      stat_word[trt_pkg::STAT_TDO_BIT]      = st_q.tdo;
   end

   // Scan register and bus state advances here; the TAP state moves in u_fsm
   always_comb begin
      st_d          = st_q;
      st_d.tck_prev = pin_s.tck;
      st_d.pready   = 1'b0;
      st_d.pslverr  = 1'b0;
      st_d.prdata   = 32'h0;

      if (rise) begin
         case (state)
            trt_pkg::TAP_CAP_IR: begin
               st_d.ir_sh = trt_pkg::IR_CAPT;
            end
            trt_pkg::TAP_SH_IR: begin
               st_d.ir_sh = {pin_s.tdi, st_q.ir_sh[trt_pkg::IR_W-1:1]};
            end
            trt_pkg::TAP_UPD_IR: begin
               st_d.ir_act = st_q.ir_sh;
            end
            trt_pkg::TAP_CAP_DR: begin
               case (path)
                  PATH_BSR: st_d.dr = ring_s;
                  PATH_ID:  st_d.dr = {{(trt_pkg::BSR_W-trt_pkg::ID_W){1'b0}}, id_word};
                  default:  st_d.dr[0] = 1'b0;
               endcase
            end
            trt_pkg::TAP_SH_DR: begin
               case (path)
                  PATH_BSR: st_d.dr = {pin_s.tdi, st_q.dr[trt_pkg::BSR_W-1:1]};
                  PATH_ID: begin
                     st_d.dr[trt_pkg::ID_W-1:0] =
                        {pin_s.tdi, st_q.dr[trt_pkg::ID_W-1:1]};
                  end
                  default:  st_d.dr[0] = pin_s.tdi;
               endcase
            end
            // Update-DR loads nothing: no pin is ever driven from the chain
            default: begin
               st_d.dr = st_q.dr;
            end
         endcase
      end

      // Test-logic-reset holds the identification read
      if (state == trt_pkg::TAP_TLR) begin
         st_d.ir_act = trt_pkg::INS_IDC;
      end

      // Output high-Z follows the active instruction
      st_d.hiz = (st_d.ir_act == trt_pkg::INS_EXT) ||
                 (st_d.ir_act == trt_pkg::INS_SMPZ);

      // Serial out moves only on a detected fall
      if (fall) begin
         if (state == trt_pkg::TAP_SH_DR) begin
            st_d.tdo    = st_q.dr[0];
            st_d.tdo_oe = 1'b1;
         end else if (state == trt_pkg::TAP_SH_IR) begin
            st_d.tdo    = st_q.ir_sh[0];
            st_d.tdo_oe = 1'b1;
         end else begin
            st_d.tdo_oe = 1'b0;
         end
      end

      // APB slave: one wait state, answer registered
      if (access) begin
         st_d.pready = 1'b1;
         case (paddr)
            trt_pkg::OFF_IDCFG: begin
               if (pwrite) begin
                  st_d.rev  = pwdata[trt_pkg::IDCFG_REV_LSB +: 4];
                  st_d.rsvd = pwdata[trt_pkg::IDCFG_RSVD_LSB +: 6];
               end else begin
                  st_d.prdata[trt_pkg::IDCFG_REV_LSB +: 4]  = st_q.rev;
                  st_d.prdata[trt_pkg::IDCFG_RSVD_LSB +: 6] = st_q.rsvd;
               end
            end
            trt_pkg::OFF_STAT: begin
               st_d.prdata = stat_word;
            end
            trt_pkg::OFF_IDW: begin
               st_d.prdata = id_word;
            end
            default: begin
               st_d.pslverr = 1'b1;
            end
         endcase
      end
   end

   // Reset comes up with the ID read active and the serial out released
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q        <= '0;
         st_q.ir_sh  <= trt_pkg::IR_CAPT;
         st_q.ir_act <= trt_pkg::INS_IDC;
         st_q.rev    <= trt_pkg::REV_RST;
         st_q.rsvd   <= trt_pkg::RSVD_RST;
      end else begin
         st_q <= st_d;
      end
   end

   assign tdo     = st_q.tdo;
   assign tdo_oe  = st_q.tdo_oe;
   assign hiz     = st_q.hiz;
   assign prdata  = st_q.prdata;
   assign pready  = st_q.pready;
   assign pslverr = st_q.pslverr;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);

   sequence id_cap_s;
      rise && state == trt_pkg::TAP_CAP_DR && st_q.ir_act == trt_pkg::INS_IDC;
   endsequence

   sequence ir_cap_s;
      rise && state == trt_pkg::TAP_CAP_IR;
   endsequence

   sequence smp_cap_s;
      rise && state == trt_pkg::TAP_CAP_DR && st_q.ir_act == trt_pkg::INS_SMP;
   endsequence

   id_lsb_a: assert property (id_cap_s |=> st_q.dr[0])
      else $error("ID capture bit 0 not one");

   id_depth_a: assert property (id_cap_s |=> st_q.dr[27:23] == 5'h07)
      else $error("ID depth code wrong");

   id_width_a: assert property (id_cap_s |=> st_q.dr[22:18] == 5'h03)
      else $error("ID width code wrong");

   id_rev_a: assert property (id_cap_s |=> st_q.dr[31:28] == $past(st_q.rev))
      else $error("ID revision field wrong");

   id_rsvd_a: assert property (id_cap_s |=> st_q.dr[17:12] == $past(st_q.rsvd))
      else $error("ID reserved field wrong");

   id_maker_a: assert property (id_cap_s |=> st_q.dr[11:1] == trt_pkg::ID_MFR)
      else $error("ID maker field wrong");

   hiz_follow_a: assert property (st_q.hiz ==
      (st_q.ir_act == 3'h0 || st_q.ir_act == 3'h2))
      else $error("High-Z does not match active instruction");

   no_preload_a: assert property (rise && state == trt_pkg::TAP_UPD_DR
      |=> $stable(st_q.dr) && !$changed(st_q.tdo))
      else $error("Update-DR altered the chain");

   id_shift_a: assert property (id_cap_s ##[1:12] (rise && state == trt_pkg::TAP_SH_DR)
      |=> st_q.dr[31] == $past(pin_s.tdi) && st_q.dr[30] == $past(st_q.dr[31]))
      else $error("ID path shift wrong");

   smp_cap_a: assert property (smp_cap_s |=> st_q.dr == $past(ring_s) && !st_q.hiz)
      else $error("Sample capture wrong");

   byp_shift_a: assert property (rise && state == trt_pkg::TAP_SH_DR &&
      st_q.ir_act == trt_pkg::INS_BYP |=> st_q.dr[0] == $past(pin_s.tdi))
      else $error("Bypass bit not loaded");

   tdo_fall_a: assert property ($changed(st_q.tdo) |-> $past(fall))
      else $error("Serial out moved away from a fall");

   tdo_shift_a: assert property (fall && state == trt_pkg::TAP_SH_DR
      |=> st_q.tdo == $past(st_q.dr[0]) && st_q.tdo_oe)
      else $error("Serial out not chain LSB");

   ir_cap_a: assert property (ir_cap_s |=> st_q.ir_sh[1:0] == 2'h1)
      else $error("Instruction capture pattern wrong");

   tlr_idc_a: assert property (state == trt_pkg::TAP_TLR |=> st_q.ir_act == 3'h1)
      else $error("Test-logic-reset did not select ID read");

   ir_upd_a: assert property ($changed(st_q.ir_act) |->
      $past(rise && state == trt_pkg::TAP_UPD_IR) || $past(state == trt_pkg::TAP_TLR))
      else $error("Instruction changed outside update");

endmodule

// >>> core/trt_pkg.sv
package trt_pkg;

   // Scan path sizes
   localparam int IR_W  = 3;
   localparam int ID_W  = 32;
   localparam int BSR_W = 54;

   // Instruction codes; 3, 5 and 6 stay unnamed
   localparam logic [2:0] INS_EXT  = 3'h0;
   localparam logic [2:0] INS_IDC  = 3'h1;
   localparam logic [2:0] INS_SMPZ = 3'h2;
   localparam logic [2:0] INS_SMP  = 3'h4;
   localparam logic [2:0] INS_BYP  = 3'h7;
   localparam logic [2:0] IR_CAPT  = 3'h1;

   // Identification word fields
   localparam logic [4:0]  ID_DEPTH = 5'h07;
   localparam logic [4:0]  ID_WIDTH = 5'h03;
   localparam logic [10:0] ID_MFR   = 11'h555;  // Arbitrary value
   localparam logic [3:0]  REV_RST  = 4'h0;
   localparam logic [5:0]  RSVD_RST = 6'h00;

   // APB map
   localparam int          APB_AW    = 12;
   localparam logic [11:0] OFF_IDCFG = 12'h000;
   localparam logic [11:0] OFF_STAT  = 12'h004;
   localparam logic [11:0] OFF_IDW   = 12'h008;
   localparam int IDCFG_REV_LSB  = 0;
   localparam int IDCFG_RSVD_LSB = 4;
   localparam int STAT_TAP_LSB   = 0;
   localparam int STAT_IR_LSB    = 4;
   localparam int STAT_HIZ_BIT   = 7;
   localparam int STAT_OE_BIT    = 8;
   localparam int STAT_TDO_BIT   = 9;

   // Pin synchroniser depth
   localparam int SYNC_STAGES = 3;

   typedef enum logic [3:0] {
      TAP_TLR, TAP_RTI, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
      TAP_PA_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
      TAP_SH_IR, TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
   } trt_tap_t;

   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } trt_jtag_t;

   typedef struct packed {
      logic              tck_prev;
      logic [IR_W-1:0]   ir_sh;
      logic [IR_W-1:0]   ir_act;
      logic [BSR_W-1:0]  dr;
      logic              tdo;
      logic              tdo_oe;
      logic              hiz;
      logic [3:0]        rev;
      logic [5:0]        rsvd;
      logic              pready;
      logic              pslverr;
      logic [31:0]       prdata;
   } trt_core_t;

endpackage

// >>> core/trt_sync.sv
module trt_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } trt_sync_st_t;

   trt_sync_st_t st_q, st_d;
   logic [W-1:0] q_nxt;

   // A bit only moves once stages two and three agree
   for (genvar i = 0; i < W; i++) begin : g_bit
      assign q_nxt[i] = (st_q.s2[i] == st_q.s3[i]) ? st_q.s3[i] : st_q.q[i];
   end

   // First stage feeds only the second
   always_comb begin
      st_d    = st_q;
      st_d.s1 = d;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      st_d.q  = q_nxt;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign q = st_q.q;

endmodule

// >>> core/trt_tap_fsm.sv
module trt_tap_fsm (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        step,
   input  wire logic        tms,
   output trt_pkg::trt_tap_t state
);

   typedef struct packed {
      trt_pkg::trt_tap_t state;
   } trt_fsm_st_t;

   trt_fsm_st_t st_q, st_d;

   // Mode select only acts on a detected test clock rise
   always_comb begin
      st_d = st_q;
      if (step) begin
         case (st_q.state)
            trt_pkg::TAP_TLR:    st_d.state = tms ? trt_pkg::TAP_TLR    : trt_pkg::TAP_RTI;
            trt_pkg::TAP_RTI:    st_d.state = tms ? trt_pkg::TAP_SEL_DR : trt_pkg::TAP_RTI;
            trt_pkg::TAP_SEL_DR: st_d.state = tms ? trt_pkg::TAP_SEL_IR : trt_pkg::TAP_CAP_DR;
            trt_pkg::TAP_CAP_DR: st_d.state = tms ? trt_pkg::TAP_EX1_DR : trt_pkg::TAP_SH_DR;
            trt_pkg::TAP_SH_DR:  st_d.state = tms ? trt_pkg::TAP_EX1_DR : trt_pkg::TAP_SH_DR;
            trt_pkg::TAP_EX1_DR: st_d.state = tms ? trt_pkg::TAP_UPD_DR : trt_pkg::TAP_PA_DR;
            trt_pkg::TAP_PA_DR:  st_d.state = tms ? trt_pkg::TAP_EX2_DR : trt_pkg::TAP_PA_DR;
            trt_pkg::TAP_EX2_DR: st_d.state = tms ? trt_pkg::TAP_UPD_DR : trt_pkg::TAP_SH_DR;
            trt_pkg::TAP_UPD_DR: st_d.state = tms ? trt_pkg::TAP_SEL_DR : trt_pkg::TAP_RTI;
            trt_pkg::TAP_SEL_IR: st_d.state = tms ? trt_pkg::TAP_TLR    : trt_pkg::TAP_CAP_IR;
            trt_pkg::TAP_CAP_IR: st_d.state = tms ? trt_pkg::TAP_EX1_IR : trt_pkg::TAP_SH_IR;
            trt_pkg::TAP_SH_IR:  st_d.state = tms ? trt_pkg::TAP_EX1_IR : trt_pkg::TAP_SH_IR;
            trt_pkg::TAP_EX1_IR: st_d.state = tms ? trt_pkg::TAP_UPD_IR : trt_pkg::TAP_PA_IR;
            trt_pkg::TAP_PA_IR:  st_d.state = tms ? trt_pkg::TAP_EX2_IR : trt_pkg::TAP_PA_IR;
            trt_pkg::TAP_EX2_IR: st_d.state = tms ? trt_pkg::TAP_UPD_IR : trt_pkg::TAP_SH_IR;
            trt_pkg::TAP_UPD_IR: st_d.state = tms ? trt_pkg::TAP_SEL_DR : trt_pkg::TAP_RTI;
            default:             st_d.state = trt_pkg::TAP_TLR;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= '{state: trt_pkg::TAP_TLR};
      end else begin
         st_q <= st_d;
      end
   end

   assign state = st_q.state;

   // State never moves between test clock rises
   step_only_a: assert property (@(posedge clk) disable iff (rst)
      $changed(st_q.state) |-> $past(step))
      else $error("TAP state moved without a test clock rise");

endmodule

// >>> verification/trt_jtag_model.sv
module trt_jtag_model (
   input  wire logic clk,
   output logic      tck,
   output logic      tms,
   output logic      tdi,
   input  wire logic tdo,
   input  wire logic tdo_oe
);
   timeunit 1ns;
   timeprecision 1ns;

   // Test clock stands low outside frames
   initial begin
      tck = 1'h0;
      tms = 1'h1;
      tdi = 1'h0;
   end

   // One test clock period of 8 clk; pins move mid-low, tdo read just before the fall
   task automatic step(input logic m, input logic d, output logic o);
      repeat (2) @(posedge clk);
      tms <= m;
      tdi <= d;
      repeat (2) @(posedge clk);
      tck <= 1'h1;
      repeat (4) @(posedge clk);
      o = tdo_oe ? tdo : ~tdo;  // A released pin reads wrong on purpose
      tck <= 1'h0;
      tdi <= ~d;       // Hold is over, so the old bit must not linger
   endtask

   // Five highs reach test-logic-reset from any state, then idle
   task automatic to_idle();
      logic o;
      repeat (5) step(1'h1, 1'h0, o);
      step(1'h0, 1'h0, o);
      repeat (6) @(posedge clk);  // Sampler lag: last rise acts after the pin falls
   endtask

   // Idle to a shift state, n bits LSB first, stop in exit-1; reserved codes never sent
   task automatic scan(input logic ir, input int n, input logic [63:0] din,
                       output logic [63:0] dout);
      logic o;
      dout = 64'h0;
      step(1'h1, 1'h0, o);
      if (ir) step(1'h1, 1'h0, o);
      step(1'h0, 1'h0, o);
      step(1'h0, 1'h0, o);
      for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
   endtask

   // Exit-1 through update back to idle
   task automatic update();
      logic o;
      step(1'h1, 1'h0, o);
      step(1'h0, 1'h0, o);
      repeat (6) @(posedge clk);  // Update acts a few clk after the pin rise
   endtask
endmodule

// >>> verification/tb_tag_ram_jtag_test_port.sv
module tb_tag_ram_jtag_test_port;
   timeunit 1ns;
   timeprecision 1ns;

   logic                       clk, rst, tck, tms, tdi, tdo, tdo_oe, hiz;
   logic                       psel, penable, pwrite, pready, pslverr, err;
   logic [trt_pkg::BSR_W-1:0]  ring;
   logic [trt_pkg::APB_AW-1:0] paddr;
   logic [31:0]                pwdata, prdata, rd;
   logic [63:0]                sh;
   int                         n_mismatch, n_tests, cyc;

   always #50 clk = ~clk;

   trt_test_port u_dut (.clk(clk), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi), .ring(ring),
      .tdo(tdo), .tdo_oe(tdo_oe), .hiz(hiz), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

   trt_jtag_model u_jtag (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
      .tdo_oe(tdo_oe));

   task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
      n_tests++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %0h seen %0h", name, exp, got);
      end
   endtask

   // One APB transfer; request held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'h1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'h1 && n < 20);
      if (n >= 20) chk("pready", 1'h1, 1'h0);
      // Answer taken at the same edge that sees pready high, then released
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask

   function automatic logic [31:0] id_word(input logic [3:0] rev, input logic [5:0] rsv);
      return {rev, 5'h07, 5'h03, rsv, trt_pkg::ID_MFR, 1'h1};
   endfunction

   // Reset state, read-only status and a refused address
   task automatic t_regs();
      apb(1'h0, trt_pkg::OFF_IDCFG, 32'h0);
      chk("idcfg_rst", 10'h000, rd[9:0]);
      apb(1'h1, trt_pkg::OFF_STAT, 32'hFFFFFFFF);
      apb(1'h0, trt_pkg::OFF_STAT, 32'h0);
      chk("stat_rst", 9'h010, rd[8:0]);
      apb(1'h0, 12'h100, 32'h0);
      chk("unmapped_err", 1'h1, err);
      chk("unmapped_data", 32'h0, rd);
      chk("tdo_oe_idle", 1'h0, tdo_oe);
      $display("test regs done");
   endtask

   // Identification word at reset and with programmed free fields
   task automatic t_idcode();
      u_jtag.to_idle();
      u_jtag.scan(1'h0, 32, 64'h0, sh);
      u_jtag.update();
      chk("id_rst", id_word(4'h0, 6'h00), sh[31:0]);
      apb(1'h1, trt_pkg::OFF_IDCFG, 32'h2DA);
      apb(1'h0, trt_pkg::OFF_IDCFG, 32'h0);
      chk("idcfg_rw", 10'h2DA, rd[9:0]);
      apb(1'h0, trt_pkg::OFF_IDW, 32'h0);
      chk("idword_reg", id_word(4'hA, 6'h2D), rd);
      u_jtag.scan(1'h0, 32, 64'h0, sh);
      u_jtag.update();
      chk("id_prog", id_word(4'hA, 6'h2D), sh[31:0]);
      $display("test idcode done");
   endtask

   // Instruction capture, late activation, then the bypass path
   task automatic t_ir();
      u_jtag.scan(1'h1, 3, 64'h7, sh);
      chk("ir_capture", 3'h1, sh[2:0]);
      chk("oe_shift", 1'h1, tdo_oe);
      apb(1'h0, trt_pkg::OFF_STAT, 32'h0);
      chk("ir_before_upd", 3'h1, rd[6:4]);
      chk("tap_exit1_ir", 4'hC, rd[3:0]);
      u_jtag.update();
      apb(1'h0, trt_pkg::OFF_STAT, 32'h0);
      chk("ir_after_upd", 3'h7, rd[6:4]);
      u_jtag.scan(1'h0, 8, 64'hB5, sh);
      u_jtag.update();
      chk("bypass", 8'h6A, sh[7:0]);
      chk("bypass_hiz", 1'h0, hiz);
      $display("test ir done");
   endtask

   // Capturing codes: chain of exact length, high-Z only for 000 and 010
   task automatic t_bsr();
      logic [2:0] codes [3];
      codes = '{3'h0, 3'h2, 3'h4};
      foreach (codes[k]) begin
         @(posedge clk);
         ring <= ~ring;
         u_jtag.scan(1'h1, 3, {61'h0, codes[k]}, sh);
         u_jtag.update();
         chk("hiz", codes[k] != 3'h4, hiz);
         u_jtag.scan(1'h0, 55, 64'h1, sh);
         u_jtag.update();
         chk("chain", {1'h1, ring}, sh[54:0]);
         chk("hiz_after_upd", codes[k] != 3'h4, hiz);
      end
      $display("test boundary done");
   endtask

   // Test-logic-reset brings back identification read
   task automatic t_tlr();
      u_jtag.scan(1'h1, 3, 64'h2, sh);
      u_jtag.update();
      chk("hiz_before_tlr", 1'h1, hiz);
      u_jtag.to_idle();
      apb(1'h0, trt_pkg::OFF_STAT, 32'h0);
      chk("tlr_instr", 3'h1, rd[6:4]);
      chk("tlr_tap_idle", 4'h1, rd[3:0]);
      chk("tlr_hiz", 1'h0, hiz);
      $display("test tlr done");
   endtask

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // Hang guard, far above the few thousand cycles the tests need
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         n_mismatch++;
         report_and_stop();
      end
   end

   initial begin
      clk = 1'h0;
      rst = 1'h1;
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      ring = 54'h2A5C3F0F1E99A5;
      repeat (8) @(posedge clk);
      rst <= 1'h0;
      repeat (4) @(posedge clk);
      t_regs();
      t_idcode();
      t_ir();
      t_bsr();
      t_tlr();
      report_and_stop();
   end
endmodule
